// ---- src/apt_params.svh ----
// Constants of the prescaled timer: offsets, field positions, resets, timing.
// Assumes inclusion by bare name from design files only.
`ifndef APT_PARAMS_SVH
`define APT_PARAMS_SVH

// Register byte offsets
`define APT_OFF_CTRL   8'h00
`define APT_OFF_CLOCK  8'h04
`define APT_OFF_STATUS 8'h08
`define APT_OFF_SCLR   8'h0C
`define APT_OFF_CV     8'h10
`define APT_OFF_AR0    8'h14
`define APT_OFF_AR1    8'h18
`define APT_OFF_PIR0   8'h1C
`define APT_OFF_PIR1   8'h20

// Control fields
`define APT_CTRL_EN    0
`define APT_CTRL_PCLR  1
`define APT_CTRL_CAL   2
`define APT_CTRL_CA0   8
`define APT_CTRL_TAPLO 16
`define APT_CTRL_TAPHI 20
`define APT_CLOCK_CEN  0
`define APT_CLOCK_SLO  8
`define APT_CLOCK_SHI  10

// Status fields
`define APT_ST_OVF     0
`define APT_ST_PER0    8
`define APT_ST_ALM0    16
`define APT_ST_BUSY    24
`define APT_ST_CLKBUSY 28

// Reset values
`define APT_RST_WORD   32'h0000_0000
`define APT_RST_TAP    5'h00

// Source-switch settle time
`define APT_CLK_PERIOD_NS 10
`define APT_CLKBUSY_NS    40
`define APT_CLKBUSY_CYC   ((`APT_CLKBUSY_NS + `APT_CLK_PERIOD_NS - 1) / `APT_CLK_PERIOD_NS)

`endif

// ---- src/apt_pkg.sv ----
// Types shared by the prescaled timer modules.
// Assumes apt_params.svh supplies all numeric constants.
package apt_pkg;

    // Prescaler clock sources
    typedef enum logic [2:0] {
        APT_SRC_RC   = 3'b000,
        APT_SRC_X32K = 3'b001,
        APT_SRC_PBUS = 3'b010,
        APT_SRC_GEN2 = 3'b011,
        APT_SRC_KHZ  = 3'b100
    } apt_src_t;

endpackage : apt_pkg

// ---- src/apt_src_if.sv ----
// Carrier between the timer core and its clock-source selector.
// Assumes both ends run on pclk.
`timescale 1ns/10ps
interface apt_src_if;
    apt_pkg::apt_src_t sel;
    logic              cen;
    logic              shutdown;
    logic              tick;

    modport core (output sel, output cen, output shutdown, input tick);
    modport src  (input sel, input cen, input shutdown, output tick);
endinterface : apt_src_if

// ---- src/apt_src_sel.sv ----
// Prescaler clock-source selector: synchronises source pins, emits ticks.
// Assumes every source pin is slower than half of pclk.
`timescale 1ns/10ps
module apt_src_sel (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic system_rc_osc,
    input  wire logic crystal_32k_osc,
    input  wire logic khz_tick_clock,
    input  wire logic shared_divided_clock_two,
    apt_src_if.src    sif
);
    logic [3:0] s1_q;
    logic [3:0] s2_q;
    logic [3:0] s3_q;
    logic [3:0] rise;
    logic       t;

    // Two-flop synchronisers, third stage for edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= 4'h0;
            s2_q <= 4'h0;
            s3_q <= 4'h0;
        end else begin
            s1_q <= {shared_divided_clock_two, khz_tick_clock, crystal_32k_osc, system_rc_osc};
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    assign rise = s2_q & ~s3_q;

    // Pick one source; shutdown leaves only the slow crystal paths [RL2] [RL12]
    always_comb begin
        case (sif.sel)
            apt_pkg::APT_SRC_RC:   t = rise[0] & ~sif.shutdown; // [RL7]
            apt_pkg::APT_SRC_X32K: t = rise[1];
            apt_pkg::APT_SRC_PBUS: t = ~sif.shutdown;           // [RL7]
            apt_pkg::APT_SRC_GEN2: t = rise[3] & ~sif.shutdown; // [RL7]
            apt_pkg::APT_SRC_KHZ:  t = rise[2];
            default:               t = 1'b0;
        endcase
    end

    assign sif.tick = t & sif.cen; // [RL8]
endmodule : apt_src_sel

// ---- src/async_prescaled_timer.sv ----
// Prescaled 32-bit timer with alarms, periodic taps and calendar mode.
// Assumes an APB master on pclk; source pins are asynchronous to pclk.
// Notes on behaviour
// RL1 - 32-bit prescaler feeds 32-bit up-counter
// RL2 - Five selectable prescaler clock sources
// RL3 - Periodic interrupts and events from prescaler
// RL4 - Alarm interrupt and event on value match
// RL5 - Overflow interrupt/event; optional clear on alarm
// RL6 - Keeps counting in shutdown; can wake system
// RL7 - Shutdown allows only 32k or 1k source
// RL8 - Timer runs on source clock, not bus
// RL9 - Frozen in debug unless both run bits
// RL10 - Software enables crystal before selecting it
// RL11 - 1k source only with crystal running
// RL12 - Generic source is shared clock two
// RL13 - Optional calendar mode with date fields
// RL14 - Interrupt controller set up before use
// RL15 - Counter clocked by chosen prescaler tap
// RL16 - Counter wraps to zero, sets overflow
// RL17 - Periodic flag on tap 0-to-1 edge
// RL18 - Clear-on-alarm clears counter, sets overflow
// RL19 - Bus writes staged until source tick; busy
// RL20 - Alarm compare each update, one-cycle match
`timescale 1ns/10ps
`include "apt_params.svh"
module async_prescaled_timer (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        system_rc_osc,
    input  wire logic        crystal_32k_osc,
    input  wire logic        khz_tick_clock,
    input  wire logic        shared_divided_clock_two,
    input  wire logic        shutdown,
    input  wire logic        debug_halt,
    input  wire logic        run_in_debug,
    input  wire logic        peripheral_debug_mask,
    output logic             irq_overflow,
    output logic      [1:0]  irq_periodic,
    output logic      [1:0]  irq_alarm,
    output logic             evt_overflow,
    output logic      [1:0]  evt_periodic,
    output logic      [1:0]  evt_alarm,
    output logic             wake_req
);
    apt_src_if sif ();

    logic [31:0] ctrl_q;
    logic [31:0] clock_q;
    logic [31:0] presc_q;
    logic [31:0] cnt_q;
    logic [31:0] ar_q [2];
    logic [4:0]  pir_q [2];
    logic [4:0]  tap_q;
    logic [31:0] stage_q [6];
    logic [5:0]  pend_q;
    logic [3:0]  clkbusy_cnt_q;
    logic        overflow_flag_q;
    logic [1:0]  periodic_flag_n_q;
    logic [1:0]  alarm_flag_n_q;
    logic        pready_q;
    logic        pslverr_q;
    logic [31:0] prdata_q;
    logic        wake_q;
    logic        ev_ovf_q;
    logic [1:0]  ev_per_q;
    logic [1:0]  ev_alm_q;

    logic        acc;
    logic        wr;
    logic        mapped;
    logic        frozen;
    logic        run_tick;
    logic        cnt_tick;
    logic [31:0] presc_nx;
    logic [31:0] cnt_inc;
    logic        wrap;
    logic [1:0]  match;
    logic        ca_hit;
    logic [1:0]  per_rise;
    logic        set_ovf;
    logic [31:0] rdata;
    logic [5:0]  wr_hit;

    // Days in a calendar month; years divisible by four are leap years
    function automatic logic [4:0] apt_mdays(input logic [3:0] mon, input logic [5:0] yr);
        case (mon)
            4'h2:                      apt_mdays = (yr[1:0] == 2'h0) ? 5'h1D : 5'h1C;
            4'h4, 4'h6, 4'h9, 4'hB:    apt_mdays = 5'h1E;
            default:                   apt_mdays = 5'h1F;
        endcase
    endfunction : apt_mdays

    // Calendar advance by one second: sec, min, hour, day, month, year
    function automatic logic [31:0] apt_cal_inc(input logic [31:0] v);
        logic [5:0] s;
        logic [5:0] mi;
        logic [4:0] h;
        logic [4:0] d;
        logic [3:0] mo;
        logic [5:0] y;
        s  = v[5:0];
        mi = v[11:6];
        h  = v[16:12];
        d  = v[21:17];
        mo = v[25:22];
        y  = v[31:26];
        if (s != 6'h3B) begin
            s = s + 6'h01;
        end else begin
            s = 6'h00;
            if (mi != 6'h3B) begin
                mi = mi + 6'h01;
            end else begin
                mi = 6'h00;
                if (h != 5'h17) begin
                    h = h + 5'h01;
                end else begin
                    h = 5'h00;
                    if (d < apt_mdays(mo, y)) begin
                        d = d + 5'h01;
                    end else begin
                        d = 5'h01;
                        if (mo < 4'hC) begin
                            mo = mo + 4'h1;
                        end else begin
                            mo = 4'h1;
                            y  = y + 6'h01;
                        end
                    end
                end
            end
        end
        apt_cal_inc = {y, mo, d, h, mi, s};
    endfunction : apt_cal_inc

    apt_src_sel u_src (
        .pclk                     (pclk),
        .presetn                  (presetn),
        .system_rc_osc            (system_rc_osc),
        .crystal_32k_osc          (crystal_32k_osc),
        .khz_tick_clock           (khz_tick_clock),
        .shared_divided_clock_two (shared_divided_clock_two),
        .sif                      (sif)
    );

    assign sif.sel      = apt_pkg::apt_src_t'(clock_q[`APT_CLOCK_SHI:`APT_CLOCK_SLO]); // [RL2]
    assign sif.cen      = clock_q[`APT_CLOCK_CEN];
    assign sif.shutdown = shutdown;

    // Bus access completes on the edge that sees pready high
    assign acc    = psel & penable & pready_q;
    assign wr     = acc & pwrite;
    assign mapped = (paddr <= `APT_OFF_PIR1) && (paddr[1:0] == 2'b00);

    // Freeze under debug unless both run permissions are set
    assign frozen   = debug_halt & ~(run_in_debug & peripheral_debug_mask); // [RL9]
    assign run_tick = sif.tick & ctrl_q[`APT_CTRL_EN] & ~frozen;             // [RL8]

    // Tap edge detection on the prescaler increment
    always_comb begin
        presc_nx    = presc_q + 32'h0000_0001;                             // [RL1]
        cnt_tick    = run_tick & ~presc_q[tap_q] & presc_nx[tap_q];        // [RL15]
        per_rise[0] = run_tick & ~presc_q[pir_q[0]] & presc_nx[pir_q[0]];  // [RL17]
        per_rise[1] = run_tick & ~presc_q[pir_q[1]] & presc_nx[pir_q[1]];  // [RL17]
        cnt_inc     = ctrl_q[`APT_CTRL_CAL] ? apt_cal_inc(cnt_q)
                                            : cnt_q + 32'h0000_0001;       // [RL13]
        wrap        = ~ctrl_q[`APT_CTRL_CAL] & (cnt_q == 32'hFFFF_FFFF);   // [RL16]
        match[0]    = cnt_tick & (cnt_inc == ar_q[0]);                     // [RL20]
        match[1]    = cnt_tick & (cnt_inc == ar_q[1]);                     // [RL20]
        ca_hit      = |(match & ctrl_q[`APT_CTRL_CA0+1:`APT_CTRL_CA0]);   // [RL18]
        set_ovf     = cnt_tick & (wrap | ca_hit);                          // [RL16] [RL18]
    end

    // Prescaler: runs on enabled, unfrozen source ticks, cleared by a control write with pclr set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc_q <= `APT_RST_WORD;
        end else if (wr && paddr == `APT_OFF_CTRL && pwdata[`APT_CTRL_PCLR]) begin
            presc_q <= `APT_RST_WORD;
        end else if (run_tick) begin
            presc_q <= presc_nx; // [RL1]
        end
    end

    // Staged writes per target: cv, ar0, ar1, pir0, pir1, tap
    always_comb begin
        wr_hit    = 6'h00;
        wr_hit[0] = wr && paddr == `APT_OFF_CV;
        wr_hit[1] = wr && paddr == `APT_OFF_AR0;
        wr_hit[2] = wr && paddr == `APT_OFF_AR1;
        wr_hit[3] = wr && paddr == `APT_OFF_PIR0;
        wr_hit[4] = wr && paddr == `APT_OFF_PIR1;
        wr_hit[5] = wr && paddr == `APT_OFF_CTRL;
    end

    // A new write in the tick cycle stays pending for the next tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_q <= 6'h00;
            for (int i = 0; i < 6; i++) begin
                stage_q[i] <= `APT_RST_WORD;
            end
        end else begin
            for (int i = 0; i < 6; i++) begin
                if (wr_hit[i]) begin
                    stage_q[i] <= pwdata;
                end
            end
            pend_q <= wr_hit | (pend_q & {6{~sif.tick}}); // [RL19]
        end
    end

    // Transfer of staged values on the source tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ar_q[0]  <= `APT_RST_WORD;
            ar_q[1]  <= `APT_RST_WORD;
            pir_q[0] <= `APT_RST_TAP;
            pir_q[1] <= `APT_RST_TAP;
            tap_q    <= `APT_RST_TAP;
        end else if (sif.tick) begin
            if (pend_q[1]) ar_q[0]  <= stage_q[1];      // [RL19]
            if (pend_q[2]) ar_q[1]  <= stage_q[2];      // [RL19]
            if (pend_q[3]) pir_q[0] <= stage_q[3][4:0];
            if (pend_q[4]) pir_q[1] <= stage_q[4][4:0];
            if (pend_q[5]) tap_q    <= stage_q[5][`APT_CTRL_TAPHI:`APT_CTRL_TAPLO];
        end
    end

    // Counter: staged write first, then count, wrap or clear on alarm
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= `APT_RST_WORD;
        end else if (sif.tick && pend_q[0]) begin
            cnt_q <= stage_q[0];                 // [RL19]
        end else if (cnt_tick) begin
            cnt_q <= ca_hit ? `APT_RST_WORD : cnt_inc; // [RL5] [RL18] [RL16]
        end
    end

    // Control and clock registers; pclr bit is write-only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q  <= `APT_RST_WORD;
            clock_q <= `APT_RST_WORD;
        end else begin
            if (wr && paddr == `APT_OFF_CTRL) begin
                ctrl_q <= pwdata & ~(32'h0000_0001 << `APT_CTRL_PCLR);
            end
            // Source may only change while the clock settles idle
            if (wr && paddr == `APT_OFF_CLOCK && clkbusy_cnt_q == 4'h0) begin
                clock_q <= pwdata;
            end
        end
    end

    // Clock busy: a fixed settle window after each accepted clock write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clkbusy_cnt_q <= 4'h0;
        end else if (wr && paddr == `APT_OFF_CLOCK && clkbusy_cnt_q == 4'h0) begin
            clkbusy_cnt_q <= 4'(`APT_CLKBUSY_CYC);
        end else if (clkbusy_cnt_q != 4'h0) begin
            clkbusy_cnt_q <= clkbusy_cnt_q - 4'h1;
        end
    end

    // Sticky status: a hardware set beats a same-cycle clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overflow_flag_q   <= 1'b0;
            periodic_flag_n_q <= 2'h0;
            alarm_flag_n_q    <= 2'h0;
        end else begin
            if (wr && paddr == `APT_OFF_SCLR) begin
                overflow_flag_q   <= set_ovf | (overflow_flag_q & ~pwdata[`APT_ST_OVF]);
                periodic_flag_n_q <= per_rise
                    | (periodic_flag_n_q & ~pwdata[`APT_ST_PER0+1:`APT_ST_PER0]);
                alarm_flag_n_q    <= match
                    | (alarm_flag_n_q & ~pwdata[`APT_ST_ALM0+1:`APT_ST_ALM0]);
            end else begin
                overflow_flag_q   <= overflow_flag_q | set_ovf; // [RL5] [RL16]
                periodic_flag_n_q <= periodic_flag_n_q | per_rise; // [RL3] [RL17]
                alarm_flag_n_q    <= alarm_flag_n_q | match;      // [RL4] [RL20]
            end
        end
    end

    // Event pulses and wake request; counting goes on in shutdown on the 32k and 1k sources
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev_ovf_q <= 1'b0;
            ev_per_q <= 2'h0;
            ev_alm_q <= 2'h0;
            wake_q   <= 1'b0;
        end else begin
            ev_ovf_q <= set_ovf;  // [RL5]
            ev_per_q <= per_rise; // [RL3]
            ev_alm_q <= match;    // [RL4]
            wake_q   <= shutdown & (overflow_flag_q | (|periodic_flag_n_q)
                                    | (|alarm_flag_n_q)); // [RL6]
        end
    end

    // Read mux
    always_comb begin
        rdata = 32'h0000_0000;
        case (paddr)
            `APT_OFF_CTRL:   rdata = ctrl_q;
            `APT_OFF_CLOCK:  rdata = clock_q;
            `APT_OFF_STATUS: begin
                rdata[`APT_ST_OVF]                   = overflow_flag_q;
                rdata[`APT_ST_PER0+1:`APT_ST_PER0]   = periodic_flag_n_q;
                rdata[`APT_ST_ALM0+1:`APT_ST_ALM0]   = alarm_flag_n_q;
                rdata[`APT_ST_BUSY]                  = |pend_q;            // [RL19]
                rdata[`APT_ST_CLKBUSY]               = clkbusy_cnt_q != 4'h0;
            end
            `APT_OFF_CV:     rdata = cnt_q;
            `APT_OFF_AR0:    rdata = ar_q[0];
            `APT_OFF_AR1:    rdata = ar_q[1];
            `APT_OFF_PIR0:   rdata = {27'h0, pir_q[0]};
            `APT_OFF_PIR1:   rdata = {27'h0, pir_q[1]};
            default:         rdata = 32'h0000_0000;
        endcase
    end

    // APB slave: one wait state, error on unmapped address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= `APT_RST_WORD;
        end else begin
            pready_q  <= psel & penable & ~pready_q;
            pslverr_q <= psel & penable & ~pready_q & ~mapped;
            if (psel && penable && !pready_q) begin
                prdata_q <= pwrite ? 32'h0000_0000 : rdata;
            end
        end
    end

    // Interrupt lines are the sticky flags themselves [RL14]
    assign prdata       = prdata_q;
    assign pready       = pready_q;
    assign pslverr      = pslverr_q;
    assign irq_overflow = overflow_flag_q;
    assign irq_periodic = periodic_flag_n_q;
    assign irq_alarm    = alarm_flag_n_q;
    assign evt_overflow = ev_ovf_q;
    assign evt_periodic = ev_per_q;
    assign evt_alarm    = ev_alm_q;
    assign wake_req     = wake_q;
endmodule : async_prescaled_timer

// ---- tb/apt_src_model.sv ----
// Far-side source model: drives the four prescaler source pins.
// Assumes pclk as time base; all pins stand low while run is low.
`timescale 1ns/10ps
module apt_src_model (
    input  wire logic pclk,
    input  wire logic run,
    output logic      rc_o,
    output logic      x32_o,
    output logic      khz_o,
    output logic      gen_o
);
    logic [7:0] cnt_q = 8'h00;

    // Free count while running; frozen when stopped
    always @(posedge pclk) begin
        if (run) begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

    // Every rate stays below half of pclk
    assign rc_o  = run & cnt_q[1];
    assign x32_o = run & cnt_q[2];
    assign khz_o = run & cnt_q[4]; // only while crystal runs
    assign gen_o = run & cnt_q[3];
endmodule : apt_src_model

// ---- tb/apt_chk.sv ----
// Checker on the timer's APB and flag outputs.
// Assumes binding to async_prescaled_timer, pclk domain only.
`timescale 1ns/10ps
module apt_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        shutdown,
    input wire logic        irq_overflow,
    input wire logic [1:0]  irq_periodic,
    input wire logic [1:0]  irq_alarm,
    input wire logic        evt_overflow,
    input wire logic [1:0]  evt_periodic,
    input wire logic [1:0]  evt_alarm,
    input wire logic        wake_req
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Bus answers after exactly one wait state
    a_one_wait:
        assert property ($rose(penable) && psel |-> !pready ##1 pready) else $error("late");
    a_ready_pulse:
        assert property (pready |=> !pready) else $error("pready held");
    a_bad_addr:
        assert property (psel && penable && pready && !pwrite && paddr > 8'h20
            |-> pslverr && prdata == 32'h0) else $error("unmapped read");
    // Flags follow their events; overflow flag clears only by software
    a_ovf_flag:
        assert property (evt_overflow |-> irq_overflow) else $error("ovf flag");
    a_ovf_clear:
        assert property ($fell(irq_overflow) |-> $past(psel && penable && pready
            && pwrite && paddr == 8'h0C && pwdata[0])) else $error("ovf lost");
    a_alm_flag:
        assert property (evt_alarm[0] |-> irq_alarm[0]) else $error("alarm flag");
    a_alm_pulse:
        assert property (evt_alarm[0] |=> !evt_alarm[0]) else $error("alarm pulse");
    a_per_flag:
        assert property (evt_periodic[0] |-> irq_periodic[0]) else $error("per flag");
    // Wake only from shutdown, one cycle after a flag
    a_wake_set:
        assert property (shutdown && (irq_overflow || |irq_alarm || |irq_periodic)
            |=> wake_req) else $error("no wake");
    a_wake_quiet:
        assert property (!shutdown |=> !wake_req) else $error("stray wake");
endmodule : apt_chk

bind async_prescaled_timer apt_chk u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .shutdown(shutdown),
    .irq_overflow(irq_overflow), .irq_periodic(irq_periodic), .irq_alarm(irq_alarm),
    .evt_overflow(evt_overflow), .evt_periodic(evt_periodic), .evt_alarm(evt_alarm),
    .wake_req(wake_req)
);

// ---- tb/async_prescaled_timer_tb_top.sv ----
// Bench: APB tasks, source model, checks against a register shadow.
// Assumes apt_chk is bound from its own file.
`timescale 1ns/10ps
module async_prescaled_timer_tb_top;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        run = 1'b0;
    logic        shutdown = 1'b0;
    logic        dbg = 1'b0;
    logic        rid = 1'b0;
    logic        pdm = 1'b0;
    logic [31:0] prdata;
    logic        pready, pslverr, irq_overflow, evt_overflow, wake_req, err;
    logic [1:0]  irq_periodic, irq_alarm, evt_periodic, evt_alarm;
    logic        rc, x32, khz, gen;
    logic [31:0] mdl [0:15] = '{default: 32'h0};
    int          bad_count = 0;
    int          compares = 0;
    int          cyc = 0;

    always #5 pclk = ~pclk;

    apt_src_model u_src (.pclk(pclk), .run(run), .rc_o(rc), .x32_o(x32),
        .khz_o(khz), .gen_o(gen));

    async_prescaled_timer uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .system_rc_osc(rc),
        .crystal_32k_osc(x32), .khz_tick_clock(khz), .shared_divided_clock_two(gen),
        .shutdown(shutdown), .debug_halt(dbg), .run_in_debug(rid),
        .peripheral_debug_mask(pdm), .irq_overflow(irq_overflow),
        .irq_periodic(irq_periodic), .irq_alarm(irq_alarm),
        .evt_overflow(evt_overflow), .evt_periodic(evt_periodic),
        .evt_alarm(evt_alarm), .wake_req(wake_req));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic print_verdict();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict

    // Hang guard: whole run needs well under this
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 30000) begin
            bad_count++;
            print_verdict();
        end
    end

    // One APB transfer; request held until pready is sampled
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        q = prdata;
        err = pslverr;
        check(32'(n < 20), 32'h1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
        mdl[a[5:2]] = d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        apb(1'b0, a, 32'h0, q);
    endtask : rd

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        rd(a, q);
        check(q, e);
    endtask : rdchk

    // Poll a status bit clear under a bound
    task automatic poll(input int b);
        logic [31:0] v;
        int n;
        n = 0;
        v = 32'hFFFFFFFF;
        while (v[b] !== 1'b0 && n < 100) begin
            rd(8'h08, v);
            n++;
        end
        check(32'(n < 100), 32'h1);
    endtask : poll

    // Source change: stop, select, restart, each step settled
    task automatic set_src(input logic [2:0] s);
        wr(8'h04, 32'h0);
        poll(28);
        wr(8'h04, {21'h0, s, 8'h00});
        poll(28);
        wr(8'h04, {21'h0, s, 8'h01});
        poll(28);
    endtask : set_src

    task automatic wait_for(input int k);
        int n;
        n = 0;
        while (n < 3000 && !(k == 0 && evt_alarm[0] === 1'b1 || k == 1
               && evt_overflow === 1'b1 || k == 2 && evt_periodic[0] === 1'b1)) begin
            @(posedge pclk);
            n++;
        end
        check(32'(n < 3000), 32'h1);
    endtask : wait_for

    initial begin
        logic [31:0] v;
        logic [31:0] a;
        v = $urandom(32'h602380A7);
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk(8'h08, 32'h0);
        rdchk(8'h24, 32'h0);
        check({31'h0, err}, 32'h1);
        apb(1'b1, 8'h02, 32'hFFFFFFFF, v);
        check({31'h0, err}, 32'h1);
        run <= 1'b1; // crystal running before it is chosen
        wr(8'h00, 32'h1);
        // Every source must advance the counter
        for (int s = 0; s < 5; s++) begin
            set_src(s[2:0]);
            rdchk(8'h04, mdl[1]);
            rd(8'h10, v);
            repeat (200) @(posedge pclk);
            rd(8'h10, a);
            check(32'(a != v), 32'h1);
        end
        set_src(3'h1);
        // Alarm at a random count
        a = $urandom_range(12, 4);
        wr(8'h10, 32'h0);
        wr(8'h14, a);
        poll(24);
        wr(8'h0C, 32'hFFFFFFFF);
        rdchk(8'h14, mdl[5]);
        wait_for(0);
        check({31'h0, irq_alarm[0]}, 32'h1);
        rdchk(8'h10, a);
        wr(8'h0C, 32'h00010000);
        check({31'h0, irq_alarm[0]}, 32'h0);
        // Periodic flag from prescaler tap
        wr(8'h1C, 32'h2);
        poll(24);
        rdchk(8'h1C, mdl[7]);
        wr(8'h0C, 32'h100);
        wait_for(2);
        check({31'h0, irq_periodic[0]}, 32'h1);
        // Wrap from the top value
        wr(8'h10, 32'hFFFFFFFE);
        poll(24);
        wait_for(1);
        rd(8'h10, v);
        check(32'(v < 2), 32'h1);
        wr(8'h0C, 32'hFFFFFFFF);
        // Clear on alarm acts as overflow
        wr(8'h10, 32'h0);
        wr(8'h14, 32'h5);
        wr(8'h00, 32'h101);
        poll(24);
        wait_for(1);
        rd(8'h10, v);
        check(32'(v < 5), 32'h1);
        rdchk(8'h00, mdl[0]);
        // Calendar: 59 s rolls to 1 min
        wr(8'h00, 32'h5);
        wr(8'h14, 32'h40);
        wr(8'h10, 32'h3B);
        poll(24);
        wait_for(0);
        rdchk(8'h10, 32'h40);
        wr(8'h00, 32'h1);
        wr(8'h0C, 32'hFFFFFFFF);
        // Debug freeze unless both run bits set
        dbg <= 1'b1;
        rid <= 1'b1;
        rd(8'h10, v);
        repeat (100) @(posedge pclk);
        rdchk(8'h10, v);
        pdm <= 1'b1;
        repeat (100) @(posedge pclk);
        rd(8'h10, a);
        check(32'(a != v), 32'h1);
        dbg <= 1'b0;
        // Shutdown: crystal keeps counting and wakes; RC stops
        shutdown <= 1'b1;
        wait_for(2);
        repeat (2) @(posedge pclk);
        check({31'h0, wake_req}, 32'h1);
        wr(8'h0C, 32'hFFFFFFFF);
        set_src(3'h0);
        rd(8'h10, v);
        repeat (100) @(posedge pclk);
        rdchk(8'h10, v);
        shutdown <= 1'b0;
        print_verdict();
    end

endmodule : async_prescaled_timer_tb_top
